// ### clk_ctrl.sv
// System clock control: prescaler, RC trim, sleep-mode clock gating.
// Assumes CPU I/O port strobes synchronous to mclk_i and a calibration
// byte input stable through the third clock after reset release.
module clk_ctrl
    import clk_ctrl_pkg::*;
(
    input  wire logic          mclk_i,
    input  wire logic          rst_n_i,
    input  wire logic [6:0]    addr_i,
    input  wire logic          data_space_i,
    input  wire logic          wr_i,
    input  wire logic          rd_i,
    input  wire logic [7:0]    wdata_i,
    input  wire logic [7:0]    cal_byte_i,
    input  wire logic          sleep_i,
    input  wire logic [2:0]    sleep_mode_select_i,
    input  wire logic          timer0_async_select_i,
    input  wire logic          crystal_source_i,
    output logic [7:0]         rdata_o,
    output logic [7:0]         rc_trim_value_o,
    output logic               sys_tick_o,
    output clk_enables_t       clk_en_o,
    output wake_sources_t      wake_en_o
);
    typedef struct packed {
        logic          cal_loaded;
        logic          divide_enable;
        logic [6:0]    divide_select;
        logic [7:0]    rc_trim;
        logic [7:0]    rdata;
        logic          asleep;
        logic [2:0]    mode_latched;
        clk_enables_t  clk_en;
        wake_sources_t wake_en;
        logic          tick_q;
    } ctrl_state_t;

    ctrl_state_t s, next_s;
    logic [1:0]  rst_sync;
    logic        rst_n;
    logic        tick;
    logic        hit_div;
    logic        hit_trim;
    logic [7:0]  factor;

    assign rst_n = rst_sync[1];

    // =====================================================
    // Address decode
    function automatic logic io_hit(input logic [6:0] a, input logic ds,
                                    input logic [5:0] off);
        return ds ? (a == ({1'b0, off} + IO_DATA_OFFSET))
                  : (a == {1'b0, off});
    endfunction

    assign hit_div  = io_hit(addr_i, data_space_i, ADDR_DIVIDER);
    assign hit_trim = io_hit(addr_i, data_space_i, ADDR_RC_TRIM);

    // =====================================================
    // Divider
    // Factor 129 - d; 129 when d is zero, 2 at the top code
    assign factor = DIV_BASE - {1'b0, s.divide_select};

    clk_div_counter u_div (
        .mclk_i   (mclk_i),
        .rst_n    (rst_n),
        .enable_i (s.divide_enable),
        .factor_i (factor),
        .tick_o   (tick)
    );

    // =====================================================
    // Next state
    always_comb begin
        clk_enables_t e;
        e = mode_enables(s.mode_latched, timer0_async_select_i, crystal_source_i);
        next_s = s;
        next_s.tick_q = tick;
        // Trim load done once, after reset release, from a stable input
        if (!s.cal_loaded) begin
            next_s.rc_trim    = cal_byte_i;
            next_s.cal_loaded = 1'b1;
        end
        if (wr_i && hit_div) begin
            next_s.divide_enable = wdata_i[DIV_ENABLE_BIT];
            if (wdata_i[DIV_ENABLE_BIT] && !s.divide_enable) begin
                next_s.divide_select = wdata_i[6:0];
            end
            // An enabling write while already enabled leaves the old select in place
            if (wdata_i[DIV_ENABLE_BIT] && s.divide_enable) begin
                next_s.divide_select = s.divide_select;
            end
        end
        if (wr_i && hit_trim && s.cal_loaded) begin
            next_s.rc_trim = wdata_i;
        end
        if (rd_i) begin
            if (hit_div) begin
                next_s.rdata = {s.divide_enable, s.divide_select};
            end else if (hit_trim) begin
                next_s.rdata = s.rc_trim;
            end else begin
                next_s.rdata = 8'h00;
            end
        end
        // Sleep state and mode latch only on a divided-clock boundary
        if (tick) begin
            next_s.asleep       = sleep_i;
            next_s.mode_latched = sleep_mode_select_i;
        end
        if (s.asleep) begin
            next_s.clk_en = e;
            next_s.wake_en.ext_irq_low_lines    = 1'b1;
            next_s.wake_en.ext_irq_high_level   = 1'b1;
            next_s.wake_en.ext_irq_high_edge    = (s.mode_latched == SM_IDLE);
            next_s.wake_en.twi_match            = 1'b1;
            next_s.wake_en.timer0               = (s.mode_latched == SM_IDLE)
                                                  || (s.mode_latched == SM_ADC_NR)
                                                  || e.asy;
            next_s.wake_en.store_program_memory = (s.mode_latched == SM_IDLE)
                                                  || (s.mode_latched == SM_ADC_NR);
            next_s.wake_en.adc                  = next_s.wake_en.store_program_memory;
            next_s.wake_en.other_io             = (s.mode_latched == SM_IDLE);
        end else begin
            next_s.clk_en  = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1,
                               asy: 1'b1, main_osc: 1'b1,
                               timer_osc: timer0_async_select_i};
            next_s.wake_en = '{default: 1'b0};
        end
    end

    // =====================================================
    // State register
    // Only the synchroniser sees the raw reset; the rest uses its output
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            s.cal_loaded    <= 1'b0;
            s.divide_enable <= DIVIDER_RESET[DIV_ENABLE_BIT];
            s.divide_select <= DIVIDER_RESET[6:0];
            s.rc_trim       <= RC_TRIM_RESET;
            s.rdata         <= 8'h00;
            s.asleep        <= 1'b0;
            s.mode_latched  <= SM_IDLE;
            s.clk_en        <= '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1,
                                 asy: 1'b1, main_osc: 1'b1, timer_osc: 1'b0};
            s.wake_en       <= '{default: 1'b0};
            s.tick_q        <= 1'b1;
        end else begin
            s.cal_loaded    <= next_s.cal_loaded;
            s.divide_enable <= next_s.divide_enable;
            s.divide_select <= next_s.divide_select;
            s.rc_trim       <= next_s.rc_trim;
            s.rdata         <= next_s.rdata;
            s.asleep        <= next_s.asleep;
            s.mode_latched  <= next_s.mode_latched;
            s.clk_en        <= next_s.clk_en;
            s.wake_en       <= next_s.wake_en;
            s.tick_q        <= next_s.tick_q;
        end
    end

    assign rdata_o         = s.rdata;
    assign rc_trim_value_o = s.rc_trim;
    assign sys_tick_o      = s.tick_q;
    assign clk_en_o        = s.clk_en;
    assign wake_en_o       = s.wake_en;

    // =====================================================
    // Checks
    chk_div_capture: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (wr_i && hit_div && wdata_i[7] && !s.divide_enable)
        |=> (s.divide_select == $past(wdata_i[6:0]) && s.divide_enable))
        else $error("select not captured on enable");

    chk_div_reject: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (wr_i && hit_div && !wdata_i[7]) |=> $stable(s.divide_select))
        else $error("select changed on disabling write");

    chk_div_clear: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (wr_i && hit_div) |=> (s.divide_enable == $past(wdata_i[7])))
        else $error("enable bit not written");

    chk_no_div_tick: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (!s.divide_enable && !$past(s.divide_enable)) |-> ##1 tick)
        else $error("undivided clock missing tick");

    chk_div_period: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (s.divide_enable && s.divide_select == 7'h7F && tick && $stable(s.divide_enable))
        |=> !tick ##1 tick)
        else $error("divide by two period wrong");

    chk_trim_write: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (wr_i && hit_trim && s.cal_loaded) |=> (rc_trim_value_o == $past(wdata_i)))
        else $error("trim write lost");

    chk_cal_load: assert property (@(posedge mclk_i) disable iff (!rst_n)
        !s.cal_loaded |=> (s.cal_loaded && rc_trim_value_o == $past(cal_byte_i)))
        else $error("calibration not loaded");

    chk_idle_gate: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (s.asleep && s.mode_latched == SM_IDLE)
        |=> (!clk_en_o.cpu && !clk_en_o.flash && clk_en_o.io && clk_en_o.adc))
        else $error("idle gating wrong");

    chk_adc_gate: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (s.asleep && s.mode_latched == SM_ADC_NR)
        |=> (!clk_en_o.io && clk_en_o.adc && !wake_en_o.other_io))
        else $error("adc noise gating wrong");

    chk_deep_gate: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (s.asleep && s.mode_latched == SM_POWER_DOWN)
        |=> (!clk_en_o.adc && !clk_en_o.main_osc && !clk_en_o.asy))
        else $error("power-down gating wrong");

    chk_sync_gate: assert property (@(posedge mclk_i) disable iff (!rst_n)
        !tick |=> $stable(s.asleep))
        else $error("sleep entered off boundary");
endmodule // clk_ctrl

// ### clk_ctrl_pkg.sv
// Constants and carrier types for the system clock control block.
// Assumes a single clock domain and an I/O register port from the CPU core.
//
// Overview of operation
// - Enable bit divides all synchronous clock domains.
// - Divided rate is source over 129 minus select.
// - Enabling write captures simultaneous select value.
// - Disabling write drops select; change only disabled.
// - Enable bit writable any time at run time.
// - Registers at I/O address, data address plus 0x20.
// - Reset loads trim from calibration high byte.
// - Trim raises oscillator frequency monotonically.
// - Idle stops only CPU and flash clocks.
// - ADC noise mode stops I/O; limited wake sources.
// - Deep modes stop synchronous clocks; keep per mode.
// - Mode codes 000,001,010,011,110,111 select modes.
// - Deep wake only low lines, high-line levels or TWI match; power-save and extended standby also wake on timer0 with async select.
// - Async clock and timer wake need async select; idle and ADC noise mode enable both regardless.
// - Standby modes need crystal or resonator source.
package clk_ctrl_pkg;
    // =====================================================
    // Register map
    localparam logic [6:0] IO_DATA_OFFSET   = 7'h20;
    localparam logic [5:0] ADDR_RC_TRIM     = 6'h31;
    localparam logic [5:0] ADDR_DIVIDER     = 6'h3C;
    localparam int         DIV_ENABLE_BIT   = 7;
    localparam logic [7:0] DIVIDER_RESET    = 8'h00;
    localparam logic [7:0] RC_TRIM_RESET    = 8'h00;
    localparam logic [7:0] DIV_BASE         = 8'h81;

    // =====================================================
    // Sleep modes
    localparam logic [2:0] SM_IDLE          = 3'h0;
    localparam logic [2:0] SM_ADC_NR        = 3'h1;
    localparam logic [2:0] SM_POWER_DOWN    = 3'h2;
    localparam logic [2:0] SM_POWER_SAVE    = 3'h3;
    localparam logic [2:0] SM_STANDBY       = 3'h6;
    localparam logic [2:0] SM_EXT_STANDBY   = 3'h7;

    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
        logic asy;
        logic main_osc;
        logic timer_osc;
    } clk_enables_t;

    typedef struct packed {
        logic ext_irq_low_lines;
        logic ext_irq_high_level;
        logic ext_irq_high_edge;
        logic twi_match;
        logic timer0;
        logic store_program_memory;
        logic adc;
        logic other_io;
    } wake_sources_t;

    // Decodes the gating table for one sleep mode
    function automatic clk_enables_t mode_enables(input logic [2:0] sm,
                                                  input logic async0,
                                                  input logic crystal);
        clk_enables_t e;
        e = '{default: 1'b0};
        e.timer_osc = async0;
        unique case (sm)
            SM_IDLE: begin
                e.io = 1'b1; e.adc = 1'b1; e.asy = 1'b1; e.main_osc = 1'b1;
            end
            SM_ADC_NR: begin
                e.adc = 1'b1; e.asy = 1'b1; e.main_osc = 1'b1;
            end
            SM_POWER_SAVE: e.asy = async0;
            // Standby keeps only the main source, never the timer oscillator
            SM_STANDBY: begin
                e.main_osc = crystal; e.timer_osc = 1'b0;
            end
            SM_EXT_STANDBY: begin
                e.asy = async0; e.main_osc = crystal;
            end
            default: e.timer_osc = 1'b0;
        endcase
        return e;
    endfunction
endpackage : clk_ctrl_pkg

// ### clk_div_counter.sv
// Glitch-free clock divider producing a one-cycle enable tick.
// Assumes the source clock as its clock; divide factor held stable by caller.
module clk_div_counter
    import clk_ctrl_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       rst_n,
    input  wire logic       enable_i,
    input  wire logic [7:0] factor_i,
    output logic            tick_o
);
    typedef struct packed {
        logic [7:0] count;
        logic       tick;
    } div_state_t;

    div_state_t s, next_s;

    // =====================================================
    // Counter
    // A new factor takes effect at once; a count already past it ends the period next cycle
    always_comb begin
        next_s = s;
        if (!enable_i) begin
            next_s.tick  = 1'b1;
            next_s.count = 8'h00;
        end else if (s.count >= factor_i - 8'h01) begin
            next_s.tick  = 1'b1;
            next_s.count = 8'h00;
        end else begin
            next_s.tick  = 1'b0;
            next_s.count = s.count + 8'h01;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{count: 8'h00, tick: 1'b1};
        end else begin
            s <= next_s;
        end
    end

    assign tick_o = s.tick;
endmodule // clk_div_counter

// ### clk_ctrl_tb.sv
// Self-checking bench for the clock control block: registers, prescaler, sleep gating.
// Assumes clk_ctrl with its own embedded assertions; the bench drives every port itself.
module clk_ctrl_tb
    import clk_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // =========================================================
    // Stimulus and observation
    logic          mclk_i                = 1'b0;
    logic          rst_n_i               = 1'b0;
    logic [6:0]    addr_i                = 7'h00;
    logic          data_space_i          = 1'b0;
    logic          wr_i                  = 1'b0;
    logic          rd_i                  = 1'b0;
    logic [7:0]    wdata_i               = 8'h00;
    logic [7:0]    cal_byte_i;
    logic          sleep_i               = 1'b0;
    logic [2:0]    sleep_mode_select_i   = 3'h0;
    logic          timer0_async_select_i = 1'b0;
    logic          crystal_source_i      = 1'b0;
    logic [7:0]    rdata_o;
    logic [7:0]    rc_trim_value_o;
    logic          sys_tick_o;
    clk_enables_t  clk_en_o;
    wake_sources_t wake_en_o;
    int            err_count             = 0;
    int            samples_checked       = 0;
    logic [31:0]   rng                   = 32'd45;

    always #10 mclk_i = ~mclk_i;

    clk_ctrl u_clk_ctrl (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .data_space_i(data_space_i),
        .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .cal_byte_i(cal_byte_i),
        .sleep_i(sleep_i), .sleep_mode_select_i(sleep_mode_select_i),
        .timer0_async_select_i(timer0_async_select_i), .crystal_source_i(crystal_source_i),
        .rdata_o(rdata_o), .rc_trim_value_o(rc_trim_value_o), .sys_tick_o(sys_tick_o),
        .clk_en_o(clk_en_o), .wake_en_o(wake_en_o));

    // =========================================================
    // Helpers
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask

    // Data-space access adds the offset; bus held one full cycle
    task automatic wr(input logic [5:0] off, input logic ds, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i       <= ds ? {1'b0, off} + IO_DATA_OFFSET : {1'b0, off};
        data_space_i <= ds;
        wdata_i      <= d;
        wr_i         <= 1'b1;
        @(posedge mclk_i);
        wr_i         <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] off, input logic ds, output logic [7:0] q);
        @(posedge mclk_i);
        addr_i       <= ds ? {1'b0, off} + IO_DATA_OFFSET : {1'b0, off};
        data_space_i <= ds;
        rd_i         <= 1'b1;
        @(posedge mclk_i);
        rd_i         <= 1'b0;
        @(negedge mclk_i);
        q = rdata_o;
    endtask

    // Cycles between two ticks; bounded so a dead divider cannot hang
    task automatic tick_gap(output int gap);
        int n;
        n = 0;
        gap = 0;
        while (sys_tick_o !== 1'b1 && n < 300) begin
            @(negedge mclk_i);
            n++;
        end
        @(negedge mclk_i);
        gap = 1;
        while (sys_tick_o !== 1'b1 && gap < 300) begin
            @(negedge mclk_i);
            gap++;
        end
        if (n >= 300 || gap >= 300) begin
            err_count++;
            $display("FAIL tick_wait expected tick seen none");
            summarize();
        end
    endtask

    // Gating table as {cpu,flash,io,adc,asy,main,timer, wake sources}
    function automatic logic [14:0] sleep_model(input int m, input logic a, input logic c);
        logic [6:0] k;
        logic [7:0] w;
        k = 7'h00;
        w = 8'hD0;
        case (m)
            0: begin k = {4'b0011, 2'b11, a}; w = 8'hFF; end
            1: begin k = {4'b0001, 2'b11, a}; w = 8'hDE; end
            3: begin k = {4'b0000, a, 1'b0, a}; w = 8'hD0 | {4'h0, a, 3'h0}; end
            6: k = {5'b00000, c, 1'b0};
            7: begin k = {4'b0000, a, c, a}; w = 8'hD0 | {4'h0, a, 3'h0}; end
            default: ;
        endcase
        return {k, w};
    endfunction

    // =========================================================
    // Main sequence
    initial begin
        logic [7:0]  q;
        logic [7:0]  d;
        logic [14:0] e;
        logic        ds;
        int          gap;
        int          div_en;
        int          div_sel;
        cal_byte_i = 8'(xs());
        div_en = 0;
        div_sel = 0;
        cyc(3);
        chk("trim_in_reset", 16'h00, 16'(rc_trim_value_o));
        chk("tick_in_reset", 16'h1, 16'(sys_tick_o));
        chk("clk_en_in_reset", 16'h7E, 16'(clk_en_o));
        chk("wake_in_reset", 16'h00, 16'(wake_en_o));
        cyc(2);
        @(posedge mclk_i);
        rst_n_i <= 1'b1;
        cyc(8);
        chk("trim_cal_load", 16'(cal_byte_i), 16'(rc_trim_value_o));
        rd(ADDR_DIVIDER, 1'b0, q);
        chk("divider_reset", 16'h00, 16'(q));
        // Trim extremes and a random value, both address spaces
        for (int i = 0; i < 3; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'(xs());
            ds = i[0];
            wr(ADDR_RC_TRIM, ds, d);
            cyc(1);
            chk("trim_value", 16'(d), 16'(rc_trim_value_o));
            rd(ADDR_RC_TRIM, ~ds, q);
            chk("trim_read", 16'(d), 16'(q));
        end
        // Data address 0x31 is I/O 0x11: must miss the trim register
        wr(6'h11, 1'b1, ~d);
        rd(6'h11, 1'b1, q);
        chk("unmapped_read", 16'h00, 16'(q));
        chk("trim_untouched", 16'(d), 16'(rc_trim_value_o));
        // Prescaler: capture, hold while enabled, reject on disable, both ends
        for (int i = 0; i < 7; i++) begin
            case (i)
                0, 1: d = 8'h80 | 8'(xs());
                2: d = 8'h7F & 8'(xs());
                3: d = 8'hFF;
                5: d = 8'h80;
                default: d = 8'h00;
            endcase
            ds = i[0];
            if (d[7] && div_en == 0) div_sel = int'(d[6:0]);
            div_en = int'(d[7]);
            wr(ADDR_DIVIDER, ds, d);
            // Long settle: a new factor applies at once; 260 cycles exceed two periods at 129
            cyc(260);
            rd(ADDR_DIVIDER, ~ds, q);
            chk("divider_read", 16'({div_en[0], div_sel[6:0]}), 16'(q));
            tick_gap(gap);
            chk("tick_gap", 16'(div_en != 0 ? 129 - div_sel : 1), 16'(gap));
        end
        // Every mode code with both timer and crystal settings
        for (int m = 0; m < 8; m++) begin
            for (int k = 0; k < 4; k++) begin
                @(posedge mclk_i);
                sleep_mode_select_i   <= 3'(m);
                timer0_async_select_i <= k[0];
                crystal_source_i      <= k[1];
                sleep_i               <= 1'b1;
                cyc(5);
                e = sleep_model(m, k[0], k[1]);
                chk("clk_en_sleep", 16'(e[14:8]), 16'(clk_en_o));
                chk("wake_en_sleep", 16'(e[7:0]), 16'(wake_en_o));
                @(posedge mclk_i);
                sleep_i <= 1'b0;
                cyc(5);
                chk("cpu_flash_wake", 16'h3, 16'({clk_en_o.cpu, clk_en_o.flash}));
            end
        end
        summarize();
    end
endmodule // clk_ctrl_tb
